//--- common/ispm_pkg.sv
// constants, types and register map of the idle/sleep power-mode controller
// Contract
// - Idle stops the CPU, system clock keeps running
// - Idle entry clears the watchdog_timer count
// - Idle keeps peripherals clocked unless stop-in-idle set
// - Idle keeps low_power_rc_oscillator on for watchdog or monitor
// - Idle exits on enabled interrupt, reset, watchdog time-out
// - Idle wake restarts CPU at once, no delay
// - Interrupt wake vectors if global enable, else continues
// - Interrupt wake from Idle sets power_down_flag
// - Non power-on resets wake CPU from Idle
// - Watchdog time-out wakes, continues, sets timeout_flag
// - Two Sleep variants: ordinary and Retention Sleep
// - Sleep shuts down the system clock oscillator
// - Fail-safe clock monitor inactive during Sleep
// - Sleep keeps low_power_rc_oscillator on if watchdog enabled
// - Brown-out circuit stays on in Sleep if enabled
// - Enabled watchdog cleared just before Sleep entry
// - Sleep disables all system-clocked peripherals
// - Sleep exits on enabled interrupt, reset, watchdog time-out
`default_nettype none
package ispm_pkg;
   localparam int ADDR_W = 8;
   localparam int PERIPH_N = 8;
   localparam int INT_N = 3;
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_PIE = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_RESET_CONTROL_REGISTER = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STATE = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_INT_STAT = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_INT_EN = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_INT_CLR = 8'h18;
   // control register fields
   localparam int CTRL_SLEEP_SEL = 0;
   localparam int CTRL_RETAIN = 1;
   localparam int CTRL_WDT_EN = 2;
   localparam int CTRL_FAIL_SAFE_CLOCK_MONITOR_EN = 3;
   localparam int CTRL_BOR_EN = 4;
   localparam int CTRL_STOP_LSB = 8;
   localparam int CTRL_W = 16;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
   // reset_control_register flag positions
   localparam int RESET_CONTROL_REGISTER_PD = 2;
   localparam int RESET_CONTROL_REGISTER_TO = 3;
   // state readback and interrupt bits
   localparam int STATE_MODE = 2;
   localparam int INT_IDLE = 0;
   localparam int INT_SLEEP = 1;
   localparam int INT_WAKE = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_IDLE = 2'b01,
      ST_SLEEP = 2'b10
   } ispm_state_e;

   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } ispm_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ispm_axi_rsp_s;
endpackage
`default_nettype wire

//--- design/ispm_ctrl.sv
// idle and sleep entry, wake-up, status flags and register slave
`default_nettype none
module ispm_ctrl
   import ispm_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic ce,
   input wire ispm_axi_req_s axi_req,
   output ispm_axi_rsp_s axi_rsp,
   input wire logic sleep_exec,
   input wire logic global_interrupt_enable,
   input wire logic [PERIPH_N-1:0] irq_pend,
   input wire logic reset_wake,
   input wire logic wdt_timeout,
   output logic cpu_clk_en,
   output logic sys_osc_en,
   output logic [PERIPH_N-1:0] periph_clk_en,
   output logic low_power_rc_oscillator_en,
   output logic fail_safe_clock_monitor_active,
   output logic bor_active,
   output logic retention_en,
   output logic wdt_clear,
   output logic vector_pulse,
   output logic resume_pulse,
   output logic irq
);
   ispm_state_e state_reg, state_next;
   logic [CTRL_W-1:0] ctrl_reg;
   logic [PERIPH_N-1:0] pie_reg;
   logic pd_reg, to_reg;
   logic mode_sleep_reg, mode_ret_reg;
   logic [INT_N-1:0] int_stat_reg, int_en_reg, int_ev;
   logic aw_have, w_have;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg, rd_data, wmask;
   logic rd_hit, wr_hit, wr_fire;
   logic wdt_en, fail_safe_clock_monitor_en, bor_en;
   logic [PERIPH_N-1:0] stop_idle;
   logic wake_irq, wake_wdt, wake_any, asleep;
   logic enter_idle, enter_sleep, wake_go;
   // control field views
   assign wdt_en = ctrl_reg[CTRL_WDT_EN];
   assign fail_safe_clock_monitor_en = ctrl_reg[CTRL_FAIL_SAFE_CLOCK_MONITOR_EN];
   assign bor_en = ctrl_reg[CTRL_BOR_EN];
   assign stop_idle = ctrl_reg[CTRL_STOP_LSB +: PERIPH_N];
   // wake sources while the CPU is halted
   assign asleep = (state_reg != ST_RUN);
   assign wake_irq = |(irq_pend & pie_reg);
   assign wake_wdt = wdt_timeout & wdt_en;
   assign wake_any = wake_irq | reset_wake | wake_wdt;
   assign wake_go = asleep & wake_any;
   assign enter_idle = (state_reg == ST_RUN) & sleep_exec & ~ctrl_reg[CTRL_SLEEP_SEL];
   assign enter_sleep = (state_reg == ST_RUN) & sleep_exec & ctrl_reg[CTRL_SLEEP_SEL];
   // power-mode state machine
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_RUN:
         begin
            if (enter_sleep)
               state_next = ST_SLEEP;
            else if (enter_idle)
               state_next = ST_IDLE;
         end
         ST_IDLE, ST_SLEEP:
         begin
            if (wake_any)
               state_next = ST_RUN;
         end
         default:
            state_next = ST_RUN;
      endcase
   end
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         state_reg <= ST_RUN;
      else if (ce)
         state_reg <= state_next;
   end
   // mode and variant caught when the instruction executes
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         mode_sleep_reg <= 1'b0;
         mode_ret_reg <= 1'b0;
      end
      else if (ce && state_reg == ST_RUN && sleep_exec)
      begin
         mode_sleep_reg <= ctrl_reg[CTRL_SLEEP_SEL];
         mode_ret_reg <= ctrl_reg[CTRL_RETAIN];
      end
   end
   // clock and oscillator controls, one edge after the decision
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         cpu_clk_en <= 1'b1;
         sys_osc_en <= 1'b1;
         low_power_rc_oscillator_en <= 1'b0;
         fail_safe_clock_monitor_active <= 1'b0;
         bor_active <= 1'b0;
         retention_en <= 1'b0;
      end
      else if (ce)
      begin
         cpu_clk_en <= (state_next == ST_RUN);
         sys_osc_en <= (state_next != ST_SLEEP);
         fail_safe_clock_monitor_active <= fail_safe_clock_monitor_en & (state_next != ST_SLEEP);
         bor_active <= bor_en;
         if (state_next == ST_SLEEP)
            low_power_rc_oscillator_en <= wdt_en;
         else
            low_power_rc_oscillator_en <= wdt_en | fail_safe_clock_monitor_en;
         retention_en <= (state_next == ST_SLEEP) &
            (enter_sleep ? ctrl_reg[CTRL_RETAIN] : mode_ret_reg);
      end
   end
   // per-peripheral clock gates
   genvar gi;
   generate
      for (gi = 0; gi < PERIPH_N; gi++)
      begin : g_periph
         always_ff @(posedge clock or negedge resetn)
         begin
            if (!resetn)
               periph_clk_en[gi] <= 1'b1;
            else if (ce)
            begin
               unique case (state_next)
                  ST_IDLE: periph_clk_en[gi] <= ~stop_idle[gi];
                  ST_SLEEP: periph_clk_en[gi] <= 1'b0;
                  default: periph_clk_en[gi] <= 1'b1;
               endcase
            end
         end
      end
   endgenerate
   // watchdog clear and resume pulses
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         wdt_clear <= 1'b0;
         vector_pulse <= 1'b0;
         resume_pulse <= 1'b0;
      end
      else if (ce)
      begin
         wdt_clear <= enter_idle | (enter_sleep & wdt_en);
         vector_pulse <= wake_go & ~reset_wake & wake_irq & global_interrupt_enable;
         resume_pulse <= wake_go & ~reset_wake &
            (wake_wdt | wake_irq) & ~(wake_irq & global_interrupt_enable);
      end
   end
   // axi write channels: address and data taken in either order
   assign wr_fire = aw_have & w_have & ~bvalid_reg;
   // mapped words: aligned and no higher than the clear register
   assign wr_hit = (aw_addr_q <= OFF_INT_CLR) & (aw_addr_q[1:0] == OFF_CTRL[1:0]);
   assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end
      else if (ce)
      begin
         if (axi_req.awvalid && awready_reg)
         begin
            aw_have <= 1'b1;
            aw_addr_q <= axi_req.awaddr;
            awready_reg <= 1'b0;
         end
         if (axi_req.wvalid && wready_reg)
         begin
            w_have <= 1'b1;
            w_data_q <= axi_req.wdata;
            w_strb_q <= axi_req.wstrb;
            wready_reg <= 1'b0;
         end
         if (wr_fire)
         begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? RESP_OKAY : RESP_DECERR;
         end
         if (bvalid_reg && axi_req.bready)
         begin
            bvalid_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end
   // software control registers
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl_reg <= CTRL_RESET;
         pie_reg <= '0;
         int_en_reg <= '0;
      end
      else if (ce && wr_fire)
      begin
         if (aw_addr_q == OFF_CTRL)
            ctrl_reg <= (ctrl_reg & ~wmask[CTRL_W-1:0]) | (w_data_q[CTRL_W-1:0] &
               wmask[CTRL_W-1:0]);
         if (aw_addr_q == OFF_PIE && w_strb_q[0])
            pie_reg <= w_data_q[PERIPH_N-1:0];
         if (aw_addr_q == OFF_INT_EN && w_strb_q[0])
            int_en_reg <= w_data_q[INT_N-1:0];
      end
   end
   // power_down and timeout flags: a wake set beats a software clear
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         pd_reg <= 1'b0;
         to_reg <= 1'b0;
      end
      else if (ce)
      begin
         if (wake_go && wake_irq)
            pd_reg <= 1'b1;
         else if (wr_fire && aw_addr_q == OFF_RESET_CONTROL_REGISTER && w_strb_q[0] && w_data_q[RESET_CONTROL_REGISTER_PD])
            pd_reg <= 1'b0;
         if (wake_go && wake_wdt)
            to_reg <= 1'b1;
         else if (wr_fire && aw_addr_q == OFF_RESET_CONTROL_REGISTER && w_strb_q[0] && w_data_q[RESET_CONTROL_REGISTER_TO])
            to_reg <= 1'b0;
      end
   end
   // sticky event status, clear register, level interrupt
   assign int_ev[INT_IDLE] = enter_idle;
   assign int_ev[INT_SLEEP] = enter_sleep;
   assign int_ev[INT_WAKE] = wake_go;
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         int_stat_reg <= '0;
         irq <= 1'b0;
      end
      else if (ce)
      begin
         if (wr_fire && aw_addr_q == OFF_INT_CLR && w_strb_q[0])
            int_stat_reg <= (int_stat_reg & ~w_data_q[INT_N-1:0]) | int_ev;
         else
            int_stat_reg <= int_stat_reg | int_ev;
         irq <= |(int_stat_reg & int_en_reg);
      end
   end
   // read data multiplexer
   always_comb
   begin
      rd_data = '0;
      rd_hit = 1'b1;
      unique case (axi_req.araddr)
         OFF_CTRL: rd_data[CTRL_W-1:0] = ctrl_reg;
         OFF_PIE: rd_data[PERIPH_N-1:0] = pie_reg;
         OFF_RESET_CONTROL_REGISTER:
         begin
            rd_data[RESET_CONTROL_REGISTER_PD] = pd_reg;
            rd_data[RESET_CONTROL_REGISTER_TO] = to_reg;
         end
         OFF_STATE:
         begin
            rd_data[1:0] = state_reg;
            rd_data[STATE_MODE] = mode_sleep_reg;
         end
         OFF_INT_STAT: rd_data[INT_N-1:0] = int_stat_reg;
         OFF_INT_EN: rd_data[INT_N-1:0] = int_en_reg;
         OFF_INT_CLR: rd_data = '0;
         default: rd_hit = 1'b0;
      endcase
   end
   // axi read channel
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= RESP_OKAY;
      end
      else if (ce)
      begin
         if (axi_req.arvalid && arready_reg)
         begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_data;
            rresp_reg <= rd_hit ? RESP_OKAY : RESP_DECERR;
         end
         else if (rvalid_reg && axi_req.rready)
         begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
         end
      end
   end
   // bus answer, straight from flops
   assign axi_rsp.awready = awready_reg;
   assign axi_rsp.wready = wready_reg;
   assign axi_rsp.bvalid = bvalid_reg;
   assign axi_rsp.bresp = bresp_reg;
   assign axi_rsp.arready = arready_reg;
   assign axi_rsp.rvalid = rvalid_reg;
   assign axi_rsp.rdata = rdata_reg;
   assign axi_rsp.rresp = rresp_reg;
   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   sequence s_enter_idle; ce && enter_idle; endsequence
   sequence s_enter_sleep; ce && enter_sleep; endsequence
   sequence s_wake; ce && wake_go; endsequence
   property p_idle_stop;
      s_enter_idle |=> !cpu_clk_en && sys_osc_en && state_reg == ST_IDLE;
   endproperty
   a_idle_stop: assert property (p_idle_stop) else $error("idle entry wrong");
   property p_idle_wdt;
      s_enter_idle |=> wdt_clear;
   endproperty
   a_idle_wdt: assert property (p_idle_wdt) else $error("no wdt clear in idle");
   property p_idle_periph;
      (ce && state_reg == ST_IDLE && !wake_any) |=> periph_clk_en == ~$past(stop_idle);
   endproperty
   a_idle_periph: assert property (p_idle_periph) else $error("idle gate bad");
   property p_idle_low_power_rc_oscillator;
      (ce && state_reg == ST_IDLE && !wake_any) |=> low_power_rc_oscillator_en == $past(wdt_en | fail_safe_clock_monitor_en);
   endproperty
   a_idle_low_power_rc_oscillator: assert property (p_idle_low_power_rc_oscillator) else $error("idle low_power_rc_oscillator bad");
   property p_wake;
      s_wake |=> cpu_clk_en && sys_osc_en && state_reg == ST_RUN;
   endproperty
   a_wake: assert property (p_wake) else $error("wake not immediate");
   property p_vector;
      (s_wake and (wake_irq && global_interrupt_enable && !reset_wake)) |=> vector_pulse && !resume_pulse
         ##1 !vector_pulse || !$past(ce);
   endproperty
   a_vector: assert property (p_vector) else $error("vector pulse bad");
   property p_pd;
      (s_wake and wake_irq) |=> pd_reg;
   endproperty
   a_pd: assert property (p_pd) else $error("power_down_flag not set");
   property p_reset_wake;
      (s_wake and reset_wake) |=> cpu_clk_en && !vector_pulse && !resume_pulse;
   endproperty
   a_reset_wake: assert property (p_reset_wake) else $error("reset wake bad");
   property p_wdt_wake;
      (s_wake and (wake_wdt && !wake_irq && !reset_wake)) |=> resume_pulse && to_reg;
   endproperty
   a_wdt_wake: assert property (p_wdt_wake) else $error("wdt wake bad");
   property p_retain;
      s_enter_sleep |=> retention_en == $past(ctrl_reg[CTRL_RETAIN]);
   endproperty
   a_retain: assert property (p_retain) else $error("retention bad");
   property p_sleep_osc;
      state_reg == ST_SLEEP |-> !sys_osc_en && !fail_safe_clock_monitor_active && periph_clk_en == '0;
   endproperty
   a_sleep_osc: assert property (p_sleep_osc) else $error("sleep clocks on");
   property p_sleep_low_power_rc_oscillator;
      (ce && state_reg == ST_SLEEP && !wake_any) |=> low_power_rc_oscillator_en == $past(wdt_en);
   endproperty
   a_sleep_low_power_rc_oscillator: assert property (p_sleep_low_power_rc_oscillator) else $error("sleep low_power_rc_oscillator bad");
   property p_bor;
      ce |=> bor_active == $past(bor_en);
   endproperty
   a_bor: assert property (p_bor) else $error("bor not kept");
   property p_sleep_wdt;
      s_enter_sleep |=> wdt_clear == $past(wdt_en) && state_reg == ST_SLEEP;
   endproperty
   a_sleep_wdt: assert property (p_sleep_wdt) else $error("sleep wdt clear bad");
endmodule
`default_nettype wire

//--- dv/ispm_core_model.sv
// core, interrupt, reset and watchdog source model
`default_nettype none
module ispm_core_model
   import ispm_pkg::*;
(
   input wire logic clock,
   input wire logic cpu_clk_en,
   output logic sleep_exec,
   output logic global_interrupt_enable,
   output logic [PERIPH_N-1:0] irq_pend,
   output logic reset_wake,
   output logic wdt_timeout
);
   timeunit 1ns;
   timeprecision 1ns;
   // all sources quiet at start
   initial
   begin
      sleep_exec = 1'b0;
      global_interrupt_enable = 1'b0;
      irq_pend = '0;
      reset_wake = 1'b0;
      wdt_timeout = 1'b0;
   end
   // a stopped core cannot execute a sleep instruction
   task automatic run_sleep();
      @(posedge clock);
      sleep_exec <= cpu_clk_en;
      @(posedge clock);
      sleep_exec <= 1'b0;
   endtask
   // one-cycle wake source: 0 interrupt, 1 reset, 2 watchdog
   task automatic wake(input int src, input logic [PERIPH_N-1:0] pend, input logic g);
      @(posedge clock);
      global_interrupt_enable <= g;
      irq_pend <= (src == 0) ? pend : '0;
      reset_wake <= (src == 1);
      wdt_timeout <= (src == 2);
      @(posedge clock);
      irq_pend <= '0;
      reset_wake <= 1'b0;
      wdt_timeout <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- dv/tb_idle_sleep_power_mode_control.sv
// self-checking bench of the idle/sleep power-mode controller
`default_nettype none
module tb_idle_sleep_power_mode_control
   import ispm_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   ispm_axi_req_s axi_req = '0;
   ispm_axi_rsp_s axi_rsp;
   logic sleep_exec, global_interrupt_enable, reset_wake, wdt_timeout;
   logic [PERIPH_N-1:0] irq_pend, periph_clk_en;
   logic cpu_clk_en, sys_osc_en, low_power_rc_oscillator_en, fail_safe_clock_monitor_active, bor_active, retention_en;
   logic wdt_clear, vector_pulse, resume_pulse, irq;
   logic [14:0] pw_now;
   logic cpu_last = 1'b1;
   logic [33:0] rd_q[$];
   logic [1:0] wr_q[$];
   logic [1:0] wk_q[$];
   logic [14:0] pw_q[$];
   int n_fail = 0;
   int comparisons = 0;
   int cycles = 0;

   always #25 clock = ~clock;

   ispm_ctrl dut_u (.clock(clock), .resetn(resetn), .ce(ce), .axi_req(axi_req),
      .axi_rsp(axi_rsp), .sleep_exec(sleep_exec), .global_interrupt_enable(global_interrupt_enable), .irq_pend(irq_pend),
      .reset_wake(reset_wake), .wdt_timeout(wdt_timeout), .cpu_clk_en(cpu_clk_en),
      .sys_osc_en(sys_osc_en), .periph_clk_en(periph_clk_en), .low_power_rc_oscillator_en(low_power_rc_oscillator_en),
      .fail_safe_clock_monitor_active(fail_safe_clock_monitor_active), .bor_active(bor_active), .retention_en(retention_en),
      .wdt_clear(wdt_clear), .vector_pulse(vector_pulse), .resume_pulse(resume_pulse),
      .irq(irq));

   ispm_core_model core_u (.clock(clock), .cpu_clk_en(cpu_clk_en), .sleep_exec(sleep_exec),
      .global_interrupt_enable(global_interrupt_enable), .irq_pend(irq_pend), .reset_wake(reset_wake), .wdt_timeout(wdt_timeout));

   // power outputs gathered for comparison
   assign pw_now = {cpu_clk_en, sys_osc_en, periph_clk_en, low_power_rc_oscillator_en, fail_safe_clock_monitor_active, bor_active,
      retention_en, wdt_clear};

   task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // bus write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
      wr_q.push_back(rs);
      @(posedge clock);
      axi_req.awvalid <= 1'b1;
      axi_req.awaddr <= a;
      axi_req.wvalid <= 1'b1;
      axi_req.wdata <= d;
      axi_req.wstrb <= 4'hF;
      axi_req.bready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
         if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
      end
      while (!axi_rsp.bvalid);
      axi_req.bready <= 1'b0;
   endtask

   // bus read, expected response and data noted first
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      rd_q.push_back(e);
      @(posedge clock);
      axi_req.arvalid <= 1'b1;
      axi_req.araddr <= a;
      axi_req.rready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
      end
      while (!axi_rsp.rvalid);
      axi_req.rready <= 1'b0;
   endtask

   // one power-down round: f is {bor, fail_safe_clock_monitor, wdt, retention}
   task automatic run_case(input logic sl, input logic [3:0] f, input int src);
      logic [7:0] mask;
      logic [7:0] p;
      logic g;
      logic [2:0] lo;
      mask = 8'($urandom);
      p = 8'($urandom) | 8'h01;
      g = 1'($urandom);
      lo = {f[1] | f[2], f[2], f[3]};
      wr(OFF_RESET_CONTROL_REGISTER, 32'hC, RESP_OKAY);
      wr(OFF_PIE, {24'h0, p}, RESP_OKAY);
      wr(OFF_CTRL, {16'h0, mask, 3'b000, f, sl}, RESP_OKAY);
      if (sl)
         pw_q.push_back({2'b00, 8'h00, f[1], 1'b0, f[3], f[0], f[1]});
      else
         pw_q.push_back({2'b01, ~mask, lo, 2'b01});
      core_u.run_sleep();
      #1;
      check("cpu_stop", cpu_clk_en, 1'b0);
      rd(OFF_STATE, {RESP_OKAY, 29'h0, sl, sl ? 2'b10 : 2'b01});
      // disabled interrupt, and watchdog while off, must not wake
      core_u.wake(0, ~p, g);
      if (!f[1])
         core_u.wake(2, '0, g);
      if (src != 1)
         wk_q.push_back((src == 0 && g) ? 2'b10 : 2'b01);
      pw_q.push_back({2'b11, 8'hFF, lo, 2'b00});
      core_u.wake(src, p, g);
      #1;
      check("cpu_wake", cpu_clk_en, 1'b1);
      rd(OFF_RESET_CONTROL_REGISTER, {RESP_OKAY, 28'h0, src == 2, src == 0, 2'b00});
   endtask

   // cycle ceiling against a hang
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_fail++;
         stop_test();
      end
   end

   // compare each result with the oldest note when it appears
   always @(posedge clock)
   begin
      if (axi_rsp.rvalid && axi_req.rready)
         check("rdata", {axi_rsp.rresp, axi_rsp.rdata}, rd_q.pop_front());
      if (axi_rsp.bvalid && axi_req.bready)
         check("bresp", axi_rsp.bresp, wr_q.pop_front());
      if (vector_pulse || resume_pulse)
         check("resume", {vector_pulse, resume_pulse}, wk_q.pop_front());
      if (resetn && cpu_clk_en !== cpu_last)
         check("power", pw_now, pw_q.pop_front());
      cpu_last = cpu_clk_en;
   end

   // main sequence
   initial
   begin
      void'($urandom(93));
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      rd(OFF_CTRL, {RESP_OKAY, 32'h0});
      rd(OFF_INT_CLR, {RESP_OKAY, 32'h0});
      rd(8'h1C, {RESP_DECERR, 32'h0});
      wr(8'h1C, 32'hFFFF_FFFF, RESP_DECERR);
      wr(OFF_INT_EN, 32'h4, RESP_OKAY);
      run_case(1'b0, 4'b0100, 0);
      run_case(1'b0, 4'b0011, 2);
      run_case(1'b0, 4'b1000, 1);
      run_case(1'b1, 4'b1110, 2);
      run_case(1'b1, 4'b1101, 0);
      run_case(1'b1, 4'b0011, 1);
      run_case(1'b1, 4'b1111, 0);
      repeat (2) @(posedge clock);
      check("irq_set", irq, 1'b1);
      wr(OFF_INT_EN, 32'h0, RESP_OKAY);
      repeat (2) @(posedge clock);
      check("irq_mask", irq, 1'b0);
      rd(OFF_INT_STAT, {RESP_OKAY, 32'h7});
      wr(OFF_INT_EN, 32'h7, RESP_OKAY);
      wr(OFF_INT_CLR, 32'h7, RESP_OKAY);
      repeat (2) @(posedge clock);
      check("irq_clr", irq, 1'b0);
      rd(OFF_INT_STAT, {RESP_OKAY, 32'h0});
      // a frozen block ignores a sleep instruction
      ce <= 1'b0;
      core_u.run_sleep();
      ce <= 1'b1;
      repeat (2) @(posedge clock);
      check("ce_freeze", cpu_clk_en, 1'b1);
      rd(OFF_STATE, {RESP_OKAY, 29'h0, 1'b1, 2'b00});
      stop_test();
   end
endmodule
`default_nettype wire
